// File: rtl/mbf_pkg.sv
package mbf_pkg;
  // Register addresses on the device control port
  localparam logic [7:0] FAULT_POWERDOWN_SELECT_ADDR = 8'h3a;
  localparam logic [7:0] MIC_SUPPLY_CONFIG_ADDR      = 8'h3b;
  // Reset values
  localparam logic [7:0] FAULT_POWERDOWN_SELECT_RST  = 8'h10;
  localparam logic [7:0] MIC_SUPPLY_CONFIG_RST       = 8'hd0;
  // Writable bit masks (read-only reserved bits stay zero)
  localparam logic [7:0] FAULT_POWERDOWN_SELECT_WMASK = 8'hf8;
  localparam logic [7:0] MIC_SUPPLY_CONFIG_WMASK      = 8'hf3;
  // Field positions in fault_powerdown_select
  localparam int SLOT1_BIT = 7;
  localparam int SLOT2_BIT = 6;
  localparam int SLOT3_BIT = 5;
  localparam int SLOT4_BIT = 4;
  // Field position of the supply level code
  localparam int LEVEL_LSB = 4;
  localparam int LEVEL_MSB = 7;
  // Fault shutdown mode codes
  localparam logic [1:0] SHUTDOWN_MODE_ONE = 2'h1;
  localparam logic [1:0] SHUTDOWN_MODE_TWO = 2'h2;
  // Fault vector positions
  localparam int FLT_LOW_CURR  = 0;
  localparam int FLT_HIGH_CURR = 1;
  localparam int FLT_OVER_VOLT = 2;
  localparam int FLT_OVER_TEMP = 3;
  // Level codes with defined voltages (7.5 V, 8 V, 8.5 V, 9 V)
  localparam logic [3:0] LEVEL_CODE_7V5 = 4'hc;
  localparam logic [3:0] LEVEL_CODE_9V0 = 4'hf;
endpackage

// File: rtl/mbf_slot_map.sv
`timescale 1ns/100ps
// Maps four fault types onto the four slots according to the shutdown mode
module mbf_slot_map
  import mbf_pkg::*;
(
  input  wire logic [1:0] shutdownMode,  // Fault shutdown mode code
  input  wire logic [3:0] faultIn,       // Fault flags by fault type
  output logic      [3:0] slotFault      // Fault per slot, index 0 is slot 1
);
  // Selection per mode; unknown modes yield no slot fault
  always_comb begin
    slotFault = 4'h0;
    unique case (shutdownMode)
      SHUTDOWN_MODE_ONE: begin
        slotFault[0] = faultIn[FLT_LOW_CURR];
        slotFault[1] = faultIn[FLT_OVER_VOLT];
        slotFault[2] = faultIn[FLT_OVER_TEMP];
        slotFault[3] = faultIn[FLT_HIGH_CURR];
      end
      SHUTDOWN_MODE_TWO: begin
        slotFault[0] = faultIn[FLT_HIGH_CURR];
        slotFault[1] = faultIn[FLT_LOW_CURR];
        slotFault[2] = faultIn[FLT_OVER_VOLT];
        slotFault[3] = faultIn[FLT_OVER_TEMP];
      end
      default: begin
        slotFault = 4'h0;
      end
    endcase
  end
endmodule

// File: rtl/mbf_fault_cfg.sv
`timescale 1ns/100ps
module mbf_fault_cfg
  import mbf_pkg::*;
(
  input  wire logic       clk,            // System clock, 40 MHz
  input  wire logic       rst_n,          // Asynchronous reset, active low
  input  wire logic       clkEn,          // Freezes all state while low
  input  wire logic       regWrite,       // Control port write strobe
  input  wire logic [7:0] regAddr,        // Control port register address
  input  wire logic [7:0] regWdata,       // Control port write data
  output logic      [7:0] regRdata,       // Read data for regAddr, registered
  input  wire logic [1:0] shutdownMode,   // Fault shutdown mode from its own register
  input  wire logic [3:0] faultIn,        // Detected faults by type
  output logic            supplyOff,      // Powers down the mic supply
  output logic            adcOff,         // Powers down all ADC channels
  output logic      [3:0] supplyLevel,    // Mic supply level code
  output logic            levelDefined    // Code lies in the 7.5 V to 9 V range
);
  logic [7:0] faultSel_reg;     // Fault powerdown select register
  logic [7:0] faultSel_next;
  logic [7:0] supplyCfg_reg;    // Mic supply config register
  logic [7:0] supplyCfg_next;
  logic [7:0] rdata_reg;        // Registered read data
  logic [7:0] rdata_next;
  logic       off_reg;          // Registered powerdown request
  logic       off_next;
  logic [3:0] slotFault;        // Faults routed to slots
  logic [3:0] slotEn;           // Slot enables, index 0 is slot 1

  // Slot routing depends on the shutdown mode
  mbf_slot_map u_map (
    .shutdownMode (shutdownMode),
    .faultIn      (faultIn),
    .slotFault    (slotFault)
  );

  // Enables gathered in slot order
  assign slotEn = {faultSel_reg[SLOT4_BIT], faultSel_reg[SLOT3_BIT],
                   faultSel_reg[SLOT2_BIT], faultSel_reg[SLOT1_BIT]};

  // Register writes; read-only reserved bits are masked to zero
  always_comb begin
    faultSel_next  = faultSel_reg;
    supplyCfg_next = supplyCfg_reg;
    if (regWrite) begin
      if (regAddr == FAULT_POWERDOWN_SELECT_ADDR) begin
        faultSel_next = regWdata & FAULT_POWERDOWN_SELECT_WMASK;
      end
      if (regAddr == MIC_SUPPLY_CONFIG_ADDR) begin
        supplyCfg_next = regWdata & MIC_SUPPLY_CONFIG_WMASK;
      end
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    unique case (regAddr)
      FAULT_POWERDOWN_SELECT_ADDR: rdata_next = faultSel_reg;
      MIC_SUPPLY_CONFIG_ADDR:      rdata_next = supplyCfg_reg;
      default:                     rdata_next = 8'h00;
    endcase
  end

  // Powerdown only for an enabled slot with its fault present
  always_comb begin
    off_next = |(slotEn & slotFault);
  end

  // State registers; reset values give slot 4 on, others off
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      faultSel_reg  <= FAULT_POWERDOWN_SELECT_RST;
      supplyCfg_reg <= MIC_SUPPLY_CONFIG_RST;
      rdata_reg     <= 8'h00;
      off_reg       <= 1'b0;
    end else if (clkEn) begin
      faultSel_reg  <= faultSel_next;
      supplyCfg_reg <= supplyCfg_next;
      rdata_reg     <= rdata_next;
      off_reg       <= off_next;
    end
  end

  // Outputs; supply and ADCs share one request by design
  assign regRdata     = rdata_reg;
  assign supplyOff    = off_reg;
  assign adcOff       = off_reg;
  assign supplyLevel  = supplyCfg_reg[LEVEL_MSB:LEVEL_LSB];
  // Codes 12..15 map to 7.5, 8, 8.5, 9 V in the analog supply
  assign levelDefined = (supplyLevel >= LEVEL_CODE_7V5) &&
                        (supplyLevel <= LEVEL_CODE_9V0);

  // Enabled slot fault leads to powerdown one cycle later
  property p_slot_off;
    @(posedge clk) disable iff (!rst_n)
      clkEn && |(slotEn & slotFault) |=> supplyOff && adcOff;
  endproperty
  a_slot_off: assert property (p_slot_off) else $error("Enabled fault missed");

  // No enabled fault means no powerdown
  property p_no_off;
    @(posedge clk) disable iff (!rst_n)
      clkEn && !(|(slotEn & slotFault)) |=> !supplyOff;
  endproperty
  a_no_off: assert property (p_no_off) else $error("Spurious powerdown");

  // Mode two over temperature with slot 4 on
  property p_temp_mode2;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_TWO && faultSel_reg[SLOT4_BIT]
        && faultIn[FLT_OVER_TEMP] |=> adcOff;
  endproperty
  a_temp_mode2: assert property (p_temp_mode2) else $error("Temp fault ignored");

  // Mode one low current through slot 1
  property p_low_mode1;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_ONE && faultSel_reg[SLOT1_BIT]
        && faultIn[FLT_LOW_CURR] |=> supplyOff;
  endproperty
  a_low_mode1: assert property (p_low_mode1) else $error("Low current ignored");

  // Mode one over voltage through slot 2
  property p_ov_mode1;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_ONE && faultSel_reg[SLOT2_BIT]
        && faultIn[FLT_OVER_VOLT] |=> supplyOff;
  endproperty
  a_ov_mode1: assert property (p_ov_mode1) else $error("Over voltage ignored");

  // Mode two over voltage through slot 3
  property p_ov_mode2;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_TWO && faultSel_reg[SLOT3_BIT]
        && faultIn[FLT_OVER_VOLT] |=> supplyOff;
  endproperty
  a_ov_mode2: assert property (p_ov_mode2) else $error("Over voltage ignored");

  // Mode two high current through slot 1
  property p_high_mode2;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_TWO && faultSel_reg[SLOT1_BIT]
        && faultIn[FLT_HIGH_CURR] |=> supplyOff;
  endproperty
  a_high_mode2: assert property (p_high_mode2) else $error("High current ignored");

  // Mode two low current through slot 2
  property p_low_mode2;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_TWO && faultSel_reg[SLOT2_BIT]
        && faultIn[FLT_LOW_CURR] |=> supplyOff;
  endproperty
  a_low_mode2: assert property (p_low_mode2) else $error("Low current ignored");

  // Mode one over temperature through slot 3
  property p_temp_mode1;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_ONE && faultSel_reg[SLOT3_BIT]
        && faultIn[FLT_OVER_TEMP] |=> supplyOff;
  endproperty
  a_temp_mode1: assert property (p_temp_mode1) else $error("Temp fault ignored");

  // Mode one high current through slot 4
  property p_high_mode1;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode == SHUTDOWN_MODE_ONE && faultSel_reg[SLOT4_BIT]
        && faultIn[FLT_HIGH_CURR] |=> adcOff;
  endproperty
  a_high_mode1: assert property (p_high_mode1) else $error("High current ignored");

  // Illegal mode never powers down
  property p_bad_mode;
    @(posedge clk) disable iff (!rst_n)
      clkEn && shutdownMode != SHUTDOWN_MODE_ONE
        && shutdownMode != SHUTDOWN_MODE_TWO |=> !supplyOff;
  endproperty
  a_bad_mode: assert property (p_bad_mode) else $error("Powerdown in bad mode");

  // Read-only reserved bits always read zero
  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
      faultSel_reg[2:0] == 3'h0 && supplyCfg_reg[3:2] == 2'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bit set");

  // A supply config write shows its level bits on supplyLevel one cycle later
  sequence s_write_level;
    clkEn && regWrite && regAddr == MIC_SUPPLY_CONFIG_ADDR;
  endsequence
  property p_level_write;
    @(posedge clk) disable iff (!rst_n)
      s_write_level |=> supplyLevel == $past(regWdata[LEVEL_MSB:LEVEL_LSB]);
  endproperty
  a_level_write: assert property (p_level_write) else $error("Level not stored");

  // A write to the select register keeps only its writable bits
  sequence s_write_select;
    clkEn && regWrite && regAddr == FAULT_POWERDOWN_SELECT_ADDR;
  endsequence
  property p_select_write;
    @(posedge clk) disable iff (!rst_n)
      s_write_select |=> faultSel_reg == ($past(regWdata) & FAULT_POWERDOWN_SELECT_WMASK);
  endproperty
  a_select_write: assert property (p_select_write) else $error("Select not stored");

  // Read data shows the select register as it stood one cycle earlier
  property p_read_select;
    @(posedge clk) disable iff (!rst_n)
      clkEn && regAddr == FAULT_POWERDOWN_SELECT_ADDR |=> regRdata == $past(faultSel_reg);
  endproperty
  a_read_select: assert property (p_read_select) else $error("Select read wrong");

  // A frozen cycle must not move any register, else powerdown could glitch
  sequence s_frozen;
    !clkEn;
  endsequence
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      s_frozen |=> $stable(faultSel_reg) && $stable(supplyCfg_reg) && $stable(regRdata)
        && $stable(supplyOff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("State moved while frozen");
endmodule

// File: sim/mic_bias_fault_powerdown_cfg_tb.sv
`timescale 1ns/100ps
// Random traffic against a cycle model of both registers and the powerdown path
module mic_bias_fault_powerdown_cfg_tb;
  import mbf_pkg::*;
  logic       clk = 1'b0;           // 40 MHz system clock
  logic       rst_n = 1'b0;         // Async reset, active low
  logic       clkEn = 1'b1;         // Clock enable
  logic       regWrite = 1'b0;      // Write strobe
  logic [7:0] regAddr = 8'h00;      // Register address
  logic [7:0] regWdata = 8'h00;     // Write data
  logic [1:0] shutdownMode = 2'h0;  // Fault shutdown mode
  logic [3:0] faultIn = 4'h0;       // Fault flags by type
  logic [7:0] regRdata;             // Read data from the design
  logic       supplyOff;            // Supply powerdown from the design
  logic       adcOff;               // ADC powerdown from the design
  logic [3:0] supplyLevel;          // Level code from the design
  logic       levelDefined;         // Defined level flag from the design
  logic [7:0] mSel;                 // Model of the slot enable register
  logic [7:0] mCfg;                 // Model of the supply config register
  logic [7:0] mRd;                  // Model read data
  logic       mOff;                 // Model powerdown
  int         fails = 0;            // Mismatch count
  int         cmp_count = 0;        // Comparison count
  int         seed = 85;            // Fixed seed for repeatable runs
  int         r;                    // Random word

  // Clock
  always #12.5 clk = ~clk;

  mbf_fault_cfg dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regWrite(regWrite),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
    .shutdownMode(shutdownMode), .faultIn(faultIn), .supplyOff(supplyOff),
    .adcOff(adcOff), .supplyLevel(supplyLevel), .levelDefined(levelDefined));

  // Slot to fault type per mode; other modes never power down
  function automatic logic offCalc(logic [1:0] md, logic [3:0] f, logic [7:0] en);
    int   map [4];
    logic hit;
    hit = 1'b0;
    if (md == SHUTDOWN_MODE_ONE) map = '{0, 2, 3, 1};
    else map = '{1, 0, 2, 3};
    for (int k = 0; k < 4; k++) if (en[7-k] && f[map[k]]) hit = 1'b1;
    return hit && (md == SHUTDOWN_MODE_ONE || md == SHUTDOWN_MODE_TWO);
  endfunction

  // Cycle model; read data shows the value held before a same-cycle write
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mSel <= 8'h10;
      mCfg <= 8'hd0;
      mRd  <= 8'h00;
      mOff <= 1'b0;
    end else if (clkEn) begin
      mRd  <= (regAddr == 8'h3a) ? mSel : (regAddr == 8'h3b) ? mCfg : 8'h00;
      mOff <= offCalc(shutdownMode, faultIn, mSel);
      if (regWrite && regAddr == 8'h3a) mSel <= regWdata & 8'hf8;
      if (regWrite && regAddr == 8'h3b) mCfg <= regWdata & 8'hf3;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Compare mid-cycle where everything has settled
  always @(negedge clk) begin
    chk({7'h00, supplyOff}, {7'h00, mOff});
    chk({7'h00, adcOff}, {7'h00, mOff});
    chk(regRdata, mRd);
    chk({4'h0, supplyLevel}, {4'h0, mCfg[7:4]});
    chk({7'h00, levelDefined}, {7'h00, mCfg[7:4] >= 4'hc});
  end

  // Stimulus: random writes, unmapped reads, all modes, a reset in mid-run
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 2000; i++) begin
      @(posedge clk);
      r = $random(seed);
      clkEn <= (r[2:0] != 3'h0);
      regWrite <= (r[4:3] == 2'h0);
      regAddr <= (r[6:5] == 2'h1) ? 8'h3b : (r[6:5] == 2'h2) ? r[15:8] : 8'h3a;
      regWdata <= r[23:16];
      shutdownMode <= r[25:24];
      faultIn <= r[29:26];
      if (i == 900) rst_n <= 1'b0;
      if (i == 903) rst_n <= 1'b1;
    end
    // Recommended setup: slot 4 on in mode two, then an over-temperature fault
    @(posedge clk);
    clkEn <= 1'b1;
    regWrite <= 1'b1;
    regAddr <= 8'h3a;
    regWdata <= 8'h10;
    shutdownMode <= 2'h2;
    faultIn <= 4'h0;
    @(posedge clk);
    regWrite <= 1'b0;
    faultIn <= 4'h8;
    @(posedge clk);
    @(negedge clk);
    chk({7'h00, supplyOff}, 8'h01);
    chk({7'h00, adcOff}, 8'h01);
    conclude;
  end

  // Watchdog: the run needs about 2000 cycles
  initial begin
    #(25 * 5000);
    fails++;
    conclude;
  end
endmodule
